// file: rtl/psasu_map.vh
// constants for the parallel signed add/sub and reversal datapath
`ifndef PSASU_MAP_VH
`define PSASU_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PSASU_CTRL_OFS   12'h000
`define PSASU_OPA_OFS    12'h004
`define PSASU_OPB_OFS    12'h008
`define PSASU_RESULT_OFS 12'h00c
`define PSASU_FLAGS_OFS  12'h010
`define PSASU_STATUS_OFS 12'h014
// ----------------------------------------
// control field layout
// ----------------------------------------
`define PSASU_OP_LSB     0
`define PSASU_OP_MSB     3
`define PSASU_COND_BIT   4
`define PSASU_DEST_BIT   5
`define PSASU_GO_BIT     8
// ----------------------------------------
// operation codes
// ----------------------------------------
`define PSASU_OP_ADD16   4'h0
`define PSASU_OP_ADD8    4'h1
`define PSASU_OP_ASX     4'h2
`define PSASU_OP_SAX     4'h3
`define PSASU_OP_REV     4'h4
`define PSASU_OP_HALFWORD_BYTE_REVERSE   4'h5
`define PSASU_OP_SIGNED_HALFWORD_REVERSE   4'h6
`define PSASU_OP_WORD_BIT_REVERSE    4'h7
// ----------------------------------------
// reset values
// ----------------------------------------
`define PSASU_RST_WORD   32'h0000_0000
`define PSASU_RST_CTRL   9'h000
`define PSASU_RST_GE     4'h0
`define PSASU_RST_NZCV   4'h0
`endif

// file: rtl/psasu_top.v
// parallel signed add/sub, exchange and reversal datapath with apb registers
// How it works
// - halfword add forms two independent 16-bit signed lane sums
// - byte add forms four independent 8-bit signed lane sums
// - halfword lane results keep low 16 bits, no carry between lanes
// - byte lane results keep low 8 bits, no carry between lanes
// - with no destination chosen, the result goes back to operand a
// - halfword add sets flag pairs to 11 when lane sum non-negative
// - byte add sets one flag per lane when lane sum non-negative
// - add-sub exchange upper result is a.hi plus b.lo
// - add-sub exchange lower result is a.lo minus b.hi
// - add-sub exchange flags: low pair from difference, high pair from sum
// - sub-add exchange lower result is a.lo plus b.hi
// - sub-add exchange upper result is a.hi minus b.lo
// - sub-add exchange flags: low pair from sum, high pair from difference
// - a failing condition leaves destination and flags unchanged
// - reversal operations leave every flag unchanged
// - word reversal swaps the four bytes end for end
// - halfword reversal swaps bytes inside each halfword
// - signed halfword reversal swaps low bytes and sign-extends
// - bit reversal puts bit i into bit 31 minus i
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "psasu_map.vh"

module psasu_top #(
  parameter AW = 12                          // apb address width
) (
  input  wire          pclk,                 // core clock
  input  wire          presetn,              // async reset, active low
  input  wire          psel,                 // apb select
  input  wire          penable,              // apb access phase
  input  wire          pwrite,               // apb direction
  input  wire [AW-1:0] paddr,                // apb byte address
  input  wire [31:0]   pwdata,               // apb write data
  input  wire [3:0]    pstrb,                // apb byte strobes
  output reg  [31:0]   prdata,               // apb read data
  output reg           pready,               // apb ready
  output reg           pslverr,              // apb error
  output reg  [3:0]    greater_equal_flags,  // lane flags
  output reg  [3:0]    nzcv_flags,           // condition flags, held
  output reg           done                  // one-cycle pulse per executed op
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [31:0] first_operand_register;
  reg  [31:0] second_operand_register;
  reg  [31:0] result;
  reg  [8:0]  ctrl;
  reg         skipped;
  reg         busy;
  reg  [31:0] next_a;
  reg  [31:0] next_b;
  reg  [8:0]  next_ctrl;
  reg  [31:0] rd_mux;
  reg         addr_ok;
  reg  [31:0] op_res;
  reg  [3:0]  op_ge;
  reg         op_sets_ge;
  integer     i;                             // loop index, operation select only
  integer     j;                             // loop index, write merge only

  wire        acc   = psel & penable & pready;
  wire        wr    = acc & pwrite;
  wire [3:0]  opc   = ctrl[`PSASU_OP_MSB:`PSASU_OP_LSB];
  wire        cond  = ctrl[`PSASU_COND_BIT];
  wire        to_b  = ctrl[`PSASU_DEST_BIT];
  wire        go    = wr && (paddr == `PSASU_CTRL_OFS) && pstrb[1] && pwdata[`PSASU_GO_BIT];

  wire [15:0] a_lo = first_operand_register[15:0];
  wire [15:0] a_hi = first_operand_register[31:16];
  wire [15:0] b_lo = second_operand_register[15:0];
  wire [15:0] b_hi = second_operand_register[31:16];

  // ----------------------------------------
  // lane arithmetic, one bit wider
  // ----------------------------------------
  // widened lanes
  wire [16:0] h_sum_lo = {a_lo[15], a_lo} + {b_lo[15], b_lo};
  wire [16:0] h_sum_hi = {a_hi[15], a_hi} + {b_hi[15], b_hi};
  wire [16:0] x_add_hi = {a_hi[15], a_hi} + {b_lo[15], b_lo};
  wire [16:0] x_sub_lo = {a_lo[15], a_lo} - {b_hi[15], b_hi};
  wire [16:0] x_add_lo = {a_lo[15], a_lo} + {b_hi[15], b_hi};
  wire [16:0] x_sub_hi = {a_hi[15], a_hi} - {b_lo[15], b_lo};

  wire [35:0] b_sums;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_byte
      assign b_sums[g*9 +: 9] = {first_operand_register[g*8+7], first_operand_register[g*8 +: 8]}
                              + {second_operand_register[g*8+7], second_operand_register[g*8 +: 8]};
    end
  endgenerate

  // ----------------------------------------
  // operation select
  // ----------------------------------------
  always @* begin
    op_res     = `PSASU_RST_WORD;
    op_ge      = greater_equal_flags;
    op_sets_ge = 1'b0;
    case (opc)
      `PSASU_OP_ADD16: begin
        op_res     = {h_sum_hi[15:0], h_sum_lo[15:0]};
        op_ge      = {{2{~h_sum_hi[16]}}, {2{~h_sum_lo[16]}}};
        op_sets_ge = 1'b1;
      end
      `PSASU_OP_ADD8: begin
        for (i = 0; i < 4; i = i + 1) begin
          op_res[i*8 +: 8] = b_sums[i*9 +: 8];
          op_ge[i]         = ~b_sums[i*9+8];
        end
        op_sets_ge = 1'b1;
      end
      `PSASU_OP_ASX: begin
        op_res     = {x_add_hi[15:0], x_sub_lo[15:0]};
        op_ge      = {{2{~x_add_hi[16]}}, {2{~x_sub_lo[16]}}};
        op_sets_ge = 1'b1;
      end
      `PSASU_OP_SAX: begin
        op_res     = {x_sub_hi[15:0], x_add_lo[15:0]};
        op_ge      = {{2{~x_sub_hi[16]}}, {2{~x_add_lo[16]}}};
        op_sets_ge = 1'b1;
      end
      `PSASU_OP_REV: begin
        op_res = {first_operand_register[7:0], first_operand_register[15:8],
                  first_operand_register[23:16], first_operand_register[31:24]};
      end
      `PSASU_OP_HALFWORD_BYTE_REVERSE: begin
        op_res = {first_operand_register[23:16], first_operand_register[31:24],
                  first_operand_register[7:0], first_operand_register[15:8]};
      end
      `PSASU_OP_SIGNED_HALFWORD_REVERSE: begin
        op_res = {{16{first_operand_register[7]}}, first_operand_register[7:0],
                  first_operand_register[15:8]};
      end
      `PSASU_OP_WORD_BIT_REVERSE: begin
        for (i = 0; i < 32; i = i + 1) begin
          op_res[31-i] = first_operand_register[i];
        end
      end
      default: begin
        op_res = result;
      end
    endcase
  end

  // ----------------------------------------
  // apb write data merge
  // ----------------------------------------
  always @* begin
    next_a    = first_operand_register;
    next_b    = second_operand_register;
    next_ctrl = ctrl;
    for (j = 0; j < 4; j = j + 1) begin
      if (wr && pstrb[j] && paddr == `PSASU_OPA_OFS) begin
        next_a[j*8 +: 8] = pwdata[j*8 +: 8];
      end
      if (wr && pstrb[j] && paddr == `PSASU_OPB_OFS) begin
        next_b[j*8 +: 8] = pwdata[j*8 +: 8];
      end
    end
    if (wr && paddr == `PSASU_CTRL_OFS && pstrb[0]) begin
      next_ctrl[7:0] = pwdata[7:0];
    end
  end

  // ----------------------------------------
  // read mux and decode
  // ----------------------------------------
  always @* begin
    addr_ok = 1'b1;
    rd_mux  = `PSASU_RST_WORD;
    case (paddr)
      `PSASU_CTRL_OFS:   rd_mux = {23'h000000, ctrl};
      `PSASU_OPA_OFS:    rd_mux = first_operand_register;
      `PSASU_OPB_OFS:    rd_mux = second_operand_register;
      `PSASU_RESULT_OFS: rd_mux = result;
      `PSASU_FLAGS_OFS:  rd_mux = {24'h000000, nzcv_flags, greater_equal_flags};
      `PSASU_STATUS_OFS: rd_mux = {30'h00000000, skipped, busy};
      default:           addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // apb slave, no wait states
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PSASU_RST_WORD;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : `PSASU_RST_WORD;
    end
  end

  // ----------------------------------------
  // execute: go stores, next cycle commits
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_operand_register  <= `PSASU_RST_WORD;
      second_operand_register <= `PSASU_RST_WORD;
      result                  <= `PSASU_RST_WORD;
      ctrl                    <= `PSASU_RST_CTRL;
      greater_equal_flags     <= `PSASU_RST_GE;
      nzcv_flags              <= `PSASU_RST_NZCV;
      skipped                 <= 1'b0;
      busy                    <= 1'b0;
      done                    <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      busy    <= go;
      done    <= busy;
      nzcv_flags <= nzcv_flags;
      if (busy) begin
        first_operand_register  <= next_a;
        second_operand_register <= next_b;
        skipped                 <= ~cond;
        if (cond) begin
          result <= op_res;
          if (!to_b) begin
            first_operand_register <= op_res;
          end else begin
            second_operand_register <= op_res;
          end
          if (op_sets_ge) begin
            greater_equal_flags <= op_ge;
          end
        end
      end else begin
        first_operand_register  <= next_a;
        second_operand_register <= next_b;
      end
    end
  end

endmodule

// file: bench/psasu_chk_sva.sv
// port assertions for the datapath top
`timescale 1ns/100ps
module psasu_chk #(parameter AW = 12) (
  input wire          pclk,                // clock
  input wire          presetn,             // reset, low
  input wire          psel,                // select
  input wire          penable,             // access
  input wire          pwrite,              // direction
  input wire [AW-1:0] paddr,               // address
  input wire [31:0]   pwdata,              // wdata
  input wire [3:0]    pstrb,               // strobes
  input wire [31:0]   prdata,              // rdata
  input wire          pready,              // ready
  input wire          pslverr,             // error
  input wire [3:0]    greater_equal_flags, // lane flags
  input wire [3:0]    nzcv_flags,          // cond flags
  input wire          done                 // op pulse
);
  // ------------------------------
  // checks
  // ------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // go write taken at this edge
  wire ctl = psel && penable && pready && pwrite && paddr == 'h0 && pstrb[1:0] == 2'h3 && pwdata[8];
  sequence pass_s; ctl && pwdata[4] && pwdata[3:0] < 4'h8; endsequence
  sequence rev_s; ctl && pwdata[3:2] == 2'h1; endsequence
  sequence skip_s; ctl && !pwdata[4]; endsequence
  sequence pair_s; ctl && pwdata[4] && (pwdata[3:0] == 4'h0 || pwdata[3:1] == 3'h1); endsequence
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready held");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
  nzcv_held_a: assert property (nzcv_flags == 4'h0) else $error("nzcv flags moved");
  go_to_done_a: assert property (pass_s |-> ##2 done) else $error("no done after go");
  done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
  flags_on_done_a: assert property ($changed(greater_equal_flags) |-> done) else $error("flags moved idle");
  rev_keeps_ge_a: assert property (rev_s |-> ##2 $stable(greater_equal_flags)) else $error("rev moved flags");
  skip_keeps_ge_a: assert property (skip_s |-> ##2 $stable(greater_equal_flags)) else $error("skip moved flags");
  flag_pairs_a: assert property (pair_s |-> ##2 greater_equal_flags[1:0] != 2'h1 && greater_equal_flags[1:0] != 2'h2
    && greater_equal_flags[3:2] != 2'h1 && greater_equal_flags[3:2] != 2'h2) else $error("flag pair split");
endmodule
bind psasu_top psasu_chk #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .greater_equal_flags(greater_equal_flags), .nzcv_flags(nzcv_flags), .done(done));

// file: bench/psasu_issue.sv
// apb issue model standing in for the core's register access
`timescale 1ns/100ps
module psasu_issue (
  input  wire        pclk,             // clock
  output reg         psel = 1'b0,      // select
  output reg         penable = 1'b0,   // access
  output reg         pwrite = 1'b0,    // direction
  output reg  [11:0] paddr = 12'h0,    // address
  output reg  [31:0] pwdata = 32'h0,   // wdata
  output reg  [3:0]  pstrb = 4'hf,     // strobes
  input  wire [31:0] prdata,           // rdata
  input  wire        pready,           // ready
  input  wire        pslverr           // error
);
  // ------------------------------
  // transfer
  // ------------------------------
  // any place can be named, mapped or not
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    // released lines show the inverse, not the old value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// file: bench/psasu_bench.sv
// self-checking bench for the add/sub and reversal datapath
`timescale 1ns/100ps
`include "psasu_map.vh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module psasu_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, gef, nzcv;
  logic [3:0] ge = 4'h0;
  logic [31:0] rs = 32'h0;
  int bad_count = 0;
  int checked = 0;
  psasu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .greater_equal_flags(gef), .nzcv_flags(nzcv), .done(done));
  psasu_issue u_iss (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ------------------------------
  // clock and helpers
  // ------------------------------
  initial forever #20 pclk = ~pclk;
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    u_iss.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_iss.xfer(1'b1, a, d, q, e);
  endtask
  // expected {flags, result} of one op
  function automatic logic [35:0] model(input logic [3:0] o, input logic [31:0] a, b, input logic [3:0] g);
    logic signed [16:0] lo, hi;
    logic signed [8:0] y;
    logic [31:0] r;
    r = 32'h0;
    lo = (o == 4'h2) ? $signed(a[15:0]) - $signed(b[31:16]) : $signed(a[15:0]) + $signed(o == 4'h3 ? b[31:16] : b[15:0]);
    hi = (o == 4'h3) ? $signed(a[31:16]) - $signed(b[15:0]) : $signed(a[31:16]) + $signed(o == 4'h2 ? b[15:0] : b[31:16]);
    case (o)
      4'h0, 4'h2, 4'h3: begin
        r = {hi[15:0], lo[15:0]};
        g = {{2{~hi[16]}}, {2{~lo[16]}}};
      end
      4'h1: for (int i = 0; i < 4; i++) begin
        y = $signed(a[8*i+:8]) + $signed(b[8*i+:8]);
        r[8*i+:8] = y[7:0];
        g[i] = ~y[8];
      end
      4'h4: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
      4'h5: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
      4'h6: r = {{16{a[7]}}, a[7:0], a[15:8]};
      default: for (int i = 0; i < 32; i++) r[i] = a[31-i];
    endcase
    return {g, r};
  endfunction
  // load operands, issue, then read result, flags and destination
  task automatic run(input logic [3:0] o, input logic c, d, input logic [31:0] a, b);
    logic [35:0] m;
    logic [31:0] q;
    logic e;
    m = model(o, a, b, ge);
    ge = c ? m[35:32] : ge;
    rs = c ? m[31:0] : rs;
    wr(`PSASU_OPA_OFS, a);
    wr(`PSASU_OPB_OFS, b);
    wr(`PSASU_CTRL_OFS, {23'h0, 1'b1, 2'h0, d, c, o});
    repeat (3) @(posedge pclk);
    rd(`PSASU_RESULT_OFS, q, e);
    `CHK("result", rs, q)
    rd(`PSASU_FLAGS_OFS, q, e);
    `CHK("flags", {28'h0, ge}, q)
    rd((c && d) ? `PSASU_OPB_OFS : `PSASU_OPA_OFS, q, e);
    `CHK("destination", c ? rs : a, q)
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  task automatic results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge pclk);
    bad_count++;
    results;
  end
  initial begin
    logic [31:0] q;
    logic e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PSASU_FLAGS_OFS, q, e);
    `CHK("reset flags", 32'h0, q)
    for (int i = 0; i < 8; i++) begin
      run(i[3:0], 1'b1, i[0], 32'h7fff_8000, 32'h0001_8000);
      run(i[3:0], 1'b1, 1'b0, 32'h7f80_01ff, 32'h0180_ff01);
    end
    run(4'h1, 1'b0, 1'b1, 32'h1234_5678, 32'h8765_4321);
    rd(`PSASU_STATUS_OFS, q, e);
    `CHK("skipped status", 32'h2, q)
    rd(12'h020, q, e);
    `CHK("unmapped error", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    results;
  end
endmodule
